// [logic/port_pin_data.sv]
`timescale 1ns/1ps
`include "port_pin_data_map.svh"

// Overview of operation
// - One 16-bit data register holds the ten pins in bits 9 down to 0.
// - Bits 15 to 10 read as zero and writes to them are dropped.
// - A pin set to port output with direction 1 is driven with its bit.
// - Reading an output pin's bit returns the stored value, not the pin.
// - Reading an input pin's bit (direction 0) returns the sampled level.
// - Writing an input pin's bit updates storage but not the pin.
// - For a non-port function direction is ignored, reads give storage.
// - A pin is driven only while the function selector picks the port.
module port_pin_data
   import port_pin_data_pkg::*;
(
   // Clock, reset and clock enable.
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Per-pin settings from the pin function controller.
   input wire logic [9:0] port_direction_select,
   input wire logic [9:0] pin_function_selector,
   // Board pins.
   input wire logic [9:0] pin_in,
   output logic [9:0] pin_out,
   output logic [9:0] pin_oe
);

   // Decode a byte address into one of the registers.
   // Only exact aligned word offsets match; anything else is refused.
   function automatic reg_sel_e decode(input logic [11:0] addr);
      reg_sel_e sel;
      sel = SEL_NONE;
      case (addr)
         `PPD_OFS_DATA: begin
            sel = SEL_DATA;
         end
         `PPD_OFS_STORED: begin
            sel = SEL_STORED;
         end
         `PPD_OFS_LEVEL: begin
            sel = SEL_LEVEL;
         end
         `PPD_OFS_DRIVE: begin
            sel = SEL_DRIVE;
         end
         default: begin
            sel = SEL_NONE;
         end
      endcase
      return sel;
   endfunction

   // Per-bit read mux: input port pins show the pin, all else storage.
   // The selector is tested first, so direction is a don't-care for a
   // pin lent to another function.
   function automatic pin_vec_t read_mix(input pin_vec_t stored,
                                         input pin_vec_t level,
                                         input pin_vec_t dir,
                                         input pin_vec_t func);
      pin_vec_t v;
      v = stored;
      for (int i = 0; i < `PPD_PIN_COUNT; i++) begin
         if (func[i] && !dir[i]) begin
            v[i] = level[i];
         end else begin
            v[i] = stored[i];
         end
      end
      return v;
   endfunction

   // Widen a pin vector to a bus word, upper bits zero.
   // The reserved bits are never stored, so they cannot read back as one.
   function automatic logic [31:0] to_word(input pin_vec_t v);
      return {22'h0, v};
   endfunction

   // Stored data and the value it takes at the next edge.
   pin_vec_t data_r;
   pin_vec_t data_nxt;

   // Pin synchroniser stages and the level that software reads.
   pin_vec_t sync1_r;
   pin_vec_t sync2_r;
   pin_vec_t sync3_r;
   pin_vec_t level_r;

   // Bus answer state.
   apb_phase_e phase_r;
   apb_phase_e phase_nxt;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;

   // Pin drive flops.
   pin_vec_t pin_out_r;
   pin_vec_t pin_oe_r;

   // Decode and write helpers.
   reg_sel_e sel;
   logic access;
   logic taken;
   logic commit;
   logic [31:0] rd_word;
   logic [15:0] wr_merged;

   // Address decode and the access phase of the bus.
   assign sel = decode(paddr);
   assign access = psel && penable;
   // A write lands only at the edge where pready is seen high.
   assign commit = access && pready_r;
   // The first access edge of a transfer, seen while the slave is idle;
   // the later edges of the same transfer must not start another one.
   assign taken = access && (phase_r == PH_IDLE);

   // Byte lanes of the 16-bit register; lanes 2 and 3 hold nothing.
   // A one-lane write keeps the other lane's stored bits.
   always_comb begin
      wr_merged = {6'h0, data_r};
      if (pstrb[0]) begin
         wr_merged[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
         wr_merged[15:8] = pwdata[15:8];
      end
   end

   // Stored data follows any committed write to the data register, whatever the pin mode.
   // Input pins and lent pins still store it, so that a later switch to
   // port output drives what software wrote last.
   always_comb begin
      data_nxt = data_r;
      if (commit && pwrite && sel == SEL_DATA) begin
         data_nxt = wr_merged[`PPD_PIN_MSB:0];
      end
   end

   // Data register. Reserved bits are simply not stored.
   // The reset is the house asynchronous one; the reset value is zero.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         data_r <= `PPD_DATA_RESET;
      end else if (clk_en) begin
         data_r <= data_nxt;
      end
   end

   // Three-stage pin synchroniser; only stage one sees the raw pin.
   // The pins may change at any moment, so stage one alone may settle
   // late, and nothing but stage two ever reads it.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sync1_r <= `PPD_PIN_RESET;
         sync2_r <= `PPD_PIN_RESET;
         sync3_r <= `PPD_PIN_RESET;
      end else if (clk_en) begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // A pin change counts once stages two and three agree, which keeps
   // a late-settling first stage from ever reaching software.
   // A bit whose stages disagree keeps its last agreed level.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         level_r <= `PPD_PIN_RESET;
      end else if (clk_en) begin
         for (int i = 0; i < `PPD_PIN_COUNT; i++) begin
            if (sync2_r[i] == sync3_r[i]) begin
               level_r[i] <= sync3_r[i];
            end
         end
      end
   end

   // Pin drive. Output data is loaded at the same edge as storage so that
   // every pin output leaves a flip-flop.
   // Taking data_nxt keeps the pin in step with the stored bit.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pin_out_r <= `PPD_PIN_RESET;
         pin_oe_r <= `PPD_PIN_RESET;
      end else if (clk_en) begin
         pin_out_r <= data_nxt;
         // Direction only matters when the port function is chosen.
         pin_oe_r <= pin_function_selector & port_direction_select;
      end
   end

   // Read word for the selected register.
   // Only the data view mixes pins and storage; the other three show
   // storage, agreed pin levels and drive enables apart for debug.
   always_comb begin
      case (sel)
         SEL_DATA: begin
            rd_word = to_word(read_mix(data_r, level_r,
                                       port_direction_select,
                                       pin_function_selector));
         end
         SEL_STORED: begin
            rd_word = to_word(data_r);
         end
         SEL_LEVEL: begin
            rd_word = to_word(level_r);
         end
         SEL_DRIVE: begin
            rd_word = to_word(pin_oe_r);
         end
         default: begin
            rd_word = 32'h00000000;
         end
      endcase
   end

   // APB phase: one wait state, then pready, then back to idle.
   // The done phase adds a guard cycle before another transfer is taken.
   always_comb begin
      case (phase_r)
         PH_IDLE: begin
            phase_nxt = access ? PH_ANSWER : PH_IDLE;
         end
         PH_ANSWER: begin
            phase_nxt = PH_DONE;
         end
         PH_DONE: begin
            phase_nxt = PH_IDLE;
         end
         default: begin
            phase_nxt = PH_IDLE;
         end
      endcase
   end

   // Phase register.
   // Frozen with the rest while the clock enable is low.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         phase_r <= PH_IDLE;
      end else if (clk_en) begin
         phase_r <= phase_nxt;
      end
   end

   // Ready pulse. The wait state lets the read data come from a
   // flip-flop at the cost of one extra cycle per transfer.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pready_r <= 1'b0;
      end else if (clk_en) begin
         pready_r <= taken;
      end
   end

   // Error answer: unmapped addresses and writes to the read-only views
   // fail. It stands only in the ready cycle, so a stale error never
   // leaks into the next transfer.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pslverr_r <= 1'b0;
      end else if (clk_en) begin
         if (taken) begin
            pslverr_r <= (sel == SEL_NONE) || (pwrite && sel != SEL_DATA);
         end else begin
            pslverr_r <= 1'b0;
         end
      end
   end

   // Read data, captured at the taken edge. A write answers with zero and
   // the bus reads zero outside the ready cycle, so no old word is left
   // standing where a careless master might take it.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         prdata_r <= 32'h00000000;
      end else if (clk_en) begin
         if (taken && !pwrite) begin
            prdata_r <= rd_word;
         end else begin
            prdata_r <= 32'h00000000;
         end
      end
   end

   // Every output is a flop seen through a plain wire.
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign pin_out = pin_out_r;
   assign pin_oe = pin_oe_r;

endmodule

// [logic/port_pin_data_map.svh]
`ifndef PORT_PIN_DATA_MAP_SVH
`define PORT_PIN_DATA_MAP_SVH

// Register byte offsets on the APB bus.
`define PPD_OFS_DATA 12'h000
`define PPD_OFS_STORED 12'h004
`define PPD_OFS_LEVEL 12'h008
`define PPD_OFS_DRIVE 12'h00c

// Field layout of the data register.
`define PPD_PIN_COUNT 10
`define PPD_PIN_MSB 9
`define PPD_REG_WIDTH 16

// Reset values.
`define PPD_DATA_RESET 10'h000
`define PPD_PIN_RESET 10'h000

// Synchroniser depth for pin inputs.
`define PPD_SYNC_STAGES 3

`endif

// [logic/port_pin_data_pkg.sv]
package port_pin_data_pkg;

   // Phase of an APB access as the slave sees it.
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_ANSWER,
      PH_DONE
   } apb_phase_e;

   // One bit per port pin.
   typedef logic [9:0] pin_vec_t;

   // Register selected by an address decode.
   typedef enum logic [2:0] {
      SEL_DATA,
      SEL_STORED,
      SEL_LEVEL,
      SEL_DRIVE,
      SEL_NONE
   } reg_sel_e;

endpackage

// [verification/board_pins.sv]
`timescale 1ns/1ps
// Board side: a driven pin shows the port's value, else the board level.
module board_pins (
   // Port side.
   input wire logic [9:0] pin_out,
   input wire logic [9:0] pin_oe,
   // Board side.
   input wire logic [9:0] board_level,
   output logic [9:0] pin_in
);
   // Whoever enables its driver owns the wire, pin by pin.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_level);
endmodule

// [verification/port_pin_data_monitor.sv]
`timescale 1ns/1ps
module port_pin_data_monitor (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   // Bus.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pin settings and pins.
   input wire logic [9:0] port_direction_select,
   input wire logic [9:0] pin_function_selector,
   input wire logic [9:0] pin_out,
   input wire logic [9:0] pin_oe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // Access edge taken, and the edge that completes it.
   sequence s_taken; psel && penable && !pready; endsequence
   sequence s_done; psel && penable && pready; endsequence
   a_ready_latency: assert property (s_taken |=> pready)
      else $error("No answer one cycle after access edge.");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("Ready stood longer than one cycle.");
   a_rsv_zero: assert property (pready |-> prdata[31:10] == 22'h0)
      else $error("Reserved read bits not zero.");
   a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
      else $error("Read data or error outside an answer.");
   a_oe_follow: assert property (!$past(reset) && $past(clk_en) |->
      pin_oe == $past(pin_function_selector & port_direction_select))
      else $error("Pin enable does not follow function and direction.");
   a_write_drive: assert property (s_done ##0 pwrite && paddr == 12'h000
      |=> pin_out == $past(pwdata[9:0]))
      else $error("Written data not on pins.");
   a_stored_read: assert property (s_done ##0 !pwrite && paddr == 12'h000
      |-> ((prdata[9:0] ^ pin_out) &
      ~(pin_function_selector & ~port_direction_select)) == 10'h000)
      else $error("Non-input pin did not read stored value.");
   a_refuse_err: assert property (s_taken ##0 (paddr > 12'h00c ||
      (pwrite && paddr != 12'h000)) |=> pslverr)
      else $error("Refused access gave no error.");
endmodule

// [verification/ten_pin_port_data_register_tb.sv]
`timescale 1ns/1ps
module ten_pin_port_data_register_tb
   import port_pin_data_pkg::*;
;
   logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready;
   logic pslverr, er, clk_en = 1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   pin_vec_t dir = 10'h000, sel = 10'h000, brd = 10'h000;
   pin_vec_t pin_in, pin_out, pin_oe;
   int mismatches = 0, n_tests = 0;
   port_pin_data DUT (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_direction_select(dir),
      .pin_function_selector(sel), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe));
   board_pins board (.pin_out(pin_out), .pin_oe(pin_oe),
      .board_level(brd), .pin_in(pin_in));
   initial forever #2 ref_clk = ~ref_clk;
   // Compare one value and count it.
   task check(input string what, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer; only the watchdog ends the wait for a dead slave.
   task apb(input int w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w != 0;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // The tests need under a hundred cycles; this limit only catches a hang.
   initial begin
      #20000;
      mismatches++;
      print_verdict;
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      apb(0, 12'h000, 0);
      check("reset data", rd, 32'h0);
      $display("test reset done");
      sel <= 10'h3ff;
      dir <= 10'h3ff;
      brd <= 10'h155;
      apb(1, 12'h000, 32'h0000_025a);
      apb(0, 12'h000, 0);
      check("output read", rd, 32'h25a);
      check("pin out", 32'(pin_out), 32'h25a);
      check("pin oe", 32'(pin_oe), 32'h3ff);
      $display("test output done");
      dir <= 10'h000;
      brd <= 10'h1c3;
      repeat (6) @(posedge ref_clk);
      apb(0, 12'h000, 0);
      check("input read", rd, 32'h1c3);
      apb(1, 12'h000, 32'h0aa);
      check("input oe", 32'(pin_oe), 32'h0);
      apb(0, 12'h004, 0);
      check("input store", rd, 32'h0aa);
      $display("test input done");
      sel <= 10'h000;
      dir <= 10'h3ff;
      apb(0, 12'h000, 0);
      check("other read", rd, 32'h0aa);
      check("other oe", 32'(pin_oe), 32'h0);
      $display("test other done");
      sel <= 10'h3f0;
      dir <= 10'h30f;
      repeat (6) @(posedge ref_clk);
      apb(0, 12'h000, 0);
      check("mixed read", rd, 32'h0ca);
      apb(0, 12'h00c, 0);
      check("mixed oe", rd, 32'h300);
      $display("test mixed done");
      // A low clock enable freezes the drive flops.
      clk_en <= 1'b0;
      sel <= 10'h3ff;
      dir <= 10'h3ff;
      repeat (4) @(posedge ref_clk);
      check("frozen oe", 32'(pin_oe), 32'h300);
      clk_en <= 1'b1;
      repeat (2) @(posedge ref_clk);
      check("thawed oe", 32'(pin_oe), 32'h3ff);
      $display("test freeze done");
      for (int i = 1; i < 5; i++) begin
         apb(1, 12'(i * 4), 32'h3ff);
         check("refused", 32'(er), 32'h1);
      end
      apb(0, 12'h004, 0);
      check("kept store", rd, 32'h0aa);
      $display("test refusal done");
      print_verdict;
   end
endmodule
bind port_pin_data port_pin_data_monitor mon (.ref_clk(ref_clk),
   .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr), .port_direction_select(port_direction_select),
   .pin_function_selector(pin_function_selector), .pin_out(pin_out),
   .pin_oe(pin_oe));
